// ---- rtl/pesb_pkg.sv ----
// Constants shared by the event status block and its management slave
package pesb_pkg;

  // Register addresses on the management interface
  localparam logic [4:0]  REG_SYMBOL_ERROR_COUNTER = 5'h14;
  localparam logic [4:0]  REG_EVENT_STATUS         = 5'h15;
  localparam logic [4:0]  REG_EVENT_ENABLE         = 5'h16;

  // Event bit positions
  localparam int POWER_ON_BIT        = 15;
  localparam int WAKE_BIT            = 14;
  localparam int WAKE_REQUEST_BIT    = 13;
  localparam int LOW_POWER_CODE_BIT  = 12;
  localparam int INIT_ERROR_BIT      = 11;
  localparam int LINK_FAIL_BIT       = 10;
  localparam int LINK_UP_BIT         = 9;
  localparam int BAD_SYMBOL_BIT      = 8;
  localparam int TRAINING_FAIL_BIT   = 7;
  localparam int NOISE_MARGIN_BIT    = 6;
  localparam int CONTROL_ERROR_BIT   = 5;
  localparam int TX_ENABLE_STUCK_BIT = 4;
  localparam int SUPPLY_LOW_BIT      = 3;
  localparam int SUPPLY_RESTORED_BIT = 2;
  localparam int OVERTEMP_BIT        = 1;
  localparam int SLEEP_ABORT_BIT     = 0;

  // Values after reset, and the value the counter saturates at
  localparam logic [15:0] STATUS_RESET  = 16'h8000;
  localparam logic [15:0] ENABLE_RESET  = 16'h8000;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] COUNTER_MAX   = 16'hFFFF;

  // Flags dropped on sleep request or undervoltage standby
  localparam logic [15:0] LINK_FLAG_CLEAR_MASK = 16'h0740;

  // Serial management frame layout
  localparam logic [4:0]  PHY_ADDR_DEFAULT = 5'h04;  // Arbitrary value
  localparam logic [5:0]  PREAMBLE_ONES    = 6'h20;
  localparam logic [4:0]  HEADER_BITS      = 5'h0E;
  localparam logic [4:0]  WRITE_TAIL_BITS  = 5'h12;
  localparam logic [4:0]  READ_DATA_BITS   = 5'h10;
  localparam logic [1:0]  SMI_START        = 2'h1;
  localparam logic [1:0]  SMI_OP_READ      = 2'h2;
  localparam logic [1:0]  SMI_OP_WRITE     = 2'h1;

  typedef enum logic [2:0] {
    PESB_PRE,
    PESB_HDR,
    PESB_TA,
    PESB_RD,
    PESB_WR
  } pesb_smi_state_t;

endpackage : pesb_pkg

// ---- rtl/pesb_smi.sv ----
// Serial management slave: frames in, register strobes out
`timescale 1ns/100ps
`default_nettype none
module pesb_smi
  import pesb_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Management pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // Own address
  input  wire logic [4:0]  phy_addr,
  // Register side
  output logic [4:0]       reg_addr,
  output logic             rd_strobe,
  input  wire logic [15:0] rd_data,
  output logic             wr_strobe,
  output logic [15:0]      wr_data,
  output logic             ctrl_err
);

  logic [1:0]      mdc_sync;
  logic [1:0]      mdio_sync;
  logic            mdc_last;
  pesb_smi_state_t state;
  logic [5:0]      ones;
  logic [4:0]      cnt;
  logic [15:0]     shift;

  // Both pins are asynchronous to core_clk
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mdc_sync  <= 2'h0;
      mdio_sync <= 2'h3;
      mdc_last  <= 1'h0;
    end else begin
      mdc_sync  <= {mdc_sync[0], mdc};
      mdio_sync <= {mdio_sync[0], mdio_in};
      mdc_last  <= mdc_sync[1];
    end
  end

  wire        mdc_rise   = mdc_sync[1] & ~mdc_last;
  wire        bit_in     = mdio_sync[1];
  wire [15:0] shift_next = {shift[14:0], bit_in};
  wire [1:0]  hdr_st     = shift_next[13:12];
  wire [1:0]  hdr_op     = shift_next[11:10];
  wire        hdr_match  = shift_next[9:5] == phy_addr;
  wire        hdr_bad    = hdr_st != SMI_START || (hdr_op != SMI_OP_READ && hdr_op != SMI_OP_WRITE);
  wire        hdr_done   = mdc_rise && state == PESB_HDR && cnt == HEADER_BITS - 5'h01;

  // Strobe at turnaround, once reg_addr already holds the new address
  assign rd_strobe = mdc_rise && state == PESB_TA;
  assign ctrl_err  = hdr_done && hdr_bad;
  assign wr_strobe = mdc_rise && state == PESB_WR && cnt == WRITE_TAIL_BITS - 5'h01;
  assign wr_data   = shift_next;

  // Reads change the pin just after the rising edge the host samples on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= PESB_PRE;
      ones     <= 6'h00;
      cnt      <= 5'h00;
      shift    <= 16'h0000;
      reg_addr <= 5'h00;
      mdio_out <= 1'h0;
      mdio_oe  <= 1'h0;
    end else if (mdc_rise) begin
      case (state)
        PESB_PRE: begin
          shift <= shift_next;
          cnt   <= 5'h01;
          if (bit_in) begin
            ones <= (ones == PREAMBLE_ONES) ? ones : ones + 6'h01;
          end else if (ones == PREAMBLE_ONES) begin
            state <= PESB_HDR;
            ones  <= 6'h00;
          end else begin
            ones <= 6'h00;
          end
        end
        PESB_HDR: begin
          shift <= shift_next;
          cnt   <= cnt + 5'h01;
          if (cnt == HEADER_BITS - 5'h01) begin
            reg_addr <= shift_next[4:0];
            cnt      <= 5'h00;
            if (hdr_bad || !hdr_match) begin
              state <= PESB_PRE;
            end else if (hdr_op == SMI_OP_READ) begin
              state <= PESB_TA;
            end else begin
              state <= PESB_WR;
            end
          end
        end
        PESB_TA: begin
          shift    <= rd_data;
          mdio_oe  <= 1'h1;
          mdio_out <= 1'h0;
          state    <= PESB_RD;
        end
        PESB_RD: begin
          cnt      <= cnt + 5'h01;
          mdio_out <= shift[15];
          shift    <= {shift[14:0], 1'h0};
          if (cnt == READ_DATA_BITS) begin
            mdio_oe  <= 1'h0;
            mdio_out <= 1'h0;
            state    <= PESB_PRE;
            cnt      <= 5'h00;
          end
        end
        PESB_WR: begin
          shift <= shift_next;
          cnt   <= cnt + 5'h01;
          if (cnt == WRITE_TAIL_BITS - 5'h01) begin
            state <= PESB_PRE;
            cnt   <= 5'h00;
          end
        end
        default: begin
          state <= PESB_PRE;
        end
      endcase
    end
  end

endmodule : pesb_smi
`default_nettype wire

// ---- rtl/pesb_top.sv ----
// Event latching, masking and symbol error counting of the PHY
`timescale 1ns/100ps
`default_nettype none
module pesb_top
  import pesb_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEFAULT
)
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Management pins
  input  wire logic mdc,
  input  wire logic mdio_in,
  output logic      mdio_out,
  output logic      mdio_oe,
  // Receive path
  input  wire logic rx_bad_symbol,
  input  wire logic rx_in_packet,
  // Link state
  input  wire logic link_up,
  input  wire logic training_fail_flag,
  input  wire logic init_error,
  input  wire logic snr_below_warn,
  // Wake and power events
  input  wire logic local_wake,
  input  wire logic remote_wake,
  input  wire logic wake_request_seen,
  input  wire logic low_power_sleep_code,
  input  wire logic sleep_timer_expired,
  input  wire logic enter_sleep_request,
  input  wire logic enter_standby_uv,
  input  wire logic uv_in_standby,
  // Faults
  input  wire logic transmit_enable_input_stuck,
  input  wire logic supply_low,
  input  wire logic supply_restored,
  input  wire logic overtemp,
  // Interrupt
  output logic      event_irq_n
);

  logic [15:0] bad_symbol_count;
  logic [15:0] event_status;
  logic [15:0] event_enable;
  logic        link_up_last;
  logic        packet_counted;

  logic [4:0]  reg_addr;
  logic        rd_strobe;
  logic        wr_strobe;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic        smi_ctrl_err;

  function automatic logic hits(input logic [4:0] addr, input logic [4:0] target);
    hits = addr == target;
  endfunction : hits

  pesb_smi u_smi (
    .core_clk  (core_clk),
    .rst       (rst),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe   (mdio_oe),
    .phy_addr  (PHY_ADDR),
    .reg_addr  (reg_addr),
    .rd_strobe (rd_strobe),
    .rd_data   (rd_data),
    .wr_strobe (wr_strobe),
    .wr_data   (wr_data),
    .ctrl_err  (smi_ctrl_err)
  );

  // Register decode
  wire counter_read = rd_strobe && hits(reg_addr, REG_SYMBOL_ERROR_COUNTER);
  wire status_read  = rd_strobe && hits(reg_addr, REG_EVENT_STATUS);
  wire enable_write = wr_strobe && hits(reg_addr, REG_EVENT_ENABLE);

  // Unmapped addresses read as zero
  assign rd_data = hits(reg_addr, REG_SYMBOL_ERROR_COUNTER) ? bad_symbol_count :
                   hits(reg_addr, REG_EVENT_STATUS)         ? event_status     :
                   hits(reg_addr, REG_EVENT_ENABLE)         ? event_enable     : 16'h0000;

  // Error counter
  wire count_hit = rx_bad_symbol && !(rx_in_packet && packet_counted);
  wire counter_full = bad_symbol_count == COUNTER_MAX;
  wire [15:0] next_bad_symbol_count =
    counter_read ? {15'h0000, count_hit} :
    (count_hit && !counter_full) ? bad_symbol_count + 16'h0001 :
    bad_symbol_count;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bad_symbol_count <= COUNTER_RESET;
      packet_counted   <= 1'h0;
    end else begin
      bad_symbol_count <= next_bad_symbol_count;
      packet_counted   <= rx_in_packet && (packet_counted || rx_bad_symbol);
    end
  end

  // Event sources, all on core_clk so no synchroniser is needed
  wire [15:0] event_hit;
  assign event_hit[POWER_ON_BIT]        = 1'h0;
  assign event_hit[WAKE_BIT]            = local_wake || remote_wake;
  assign event_hit[WAKE_REQUEST_BIT]    = wake_request_seen;
  assign event_hit[LOW_POWER_CODE_BIT]  = low_power_sleep_code;
  assign event_hit[INIT_ERROR_BIT]      = init_error;
  assign event_hit[LINK_FAIL_BIT]       = link_up_last && !link_up;
  assign event_hit[LINK_UP_BIT]         = !link_up_last && link_up;
  assign event_hit[BAD_SYMBOL_BIT]      = rx_bad_symbol;
  assign event_hit[TRAINING_FAIL_BIT]   = training_fail_flag;
  assign event_hit[NOISE_MARGIN_BIT]    = snr_below_warn && link_up;
  assign event_hit[CONTROL_ERROR_BIT]   = smi_ctrl_err;
  assign event_hit[TX_ENABLE_STUCK_BIT] = transmit_enable_input_stuck;
  assign event_hit[SUPPLY_LOW_BIT]      = supply_low;
  assign event_hit[SUPPLY_RESTORED_BIT] = supply_restored;
  assign event_hit[OVERTEMP_BIT]        = overtemp;
  assign event_hit[SLEEP_ABORT_BIT]     = sleep_timer_expired;

  wire        link_flag_drop = enter_sleep_request || enter_standby_uv || uv_in_standby;
  wire [15:0] drop_mask      = link_flag_drop ? LINK_FLAG_CLEAR_MASK : 16'h0000;
  wire [15:0] read_mask      = status_read ? 16'hFFFF : 16'h0000;
  wire [15:0] next_event_status;

  // A cause present in the clearing cycle keeps its flag set
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_flag
      assign next_event_status[i] = event_hit[i] ||
                                    (event_status[i] && !read_mask[i] && !drop_mask[i]);
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_status <= STATUS_RESET;
      link_up_last <= 1'h0;
    end else begin
      event_status <= next_event_status;
      link_up_last <= link_up;
    end
  end

  // Enable register and interrupt
  wire next_irq_n = ~|(next_event_status & event_enable);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_enable <= ENABLE_RESET;
      event_irq_n  <= 1'h1;
    end else begin
      if (enable_write) begin
        event_enable <= wr_data;
      end
      event_irq_n <= next_irq_n;
    end
  end

endmodule : pesb_top
`default_nettype wire

// ---- tb/pesb_checker.sv ----
// Port-level checks of the event status block
`timescale 1ns/100ps
`default_nettype none
module pesb_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Management and interrupt
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic event_irq_n,
  // Flag clearing
  input wire logic enter_sleep_request,
  input wire logic enter_standby_uv,
  input wire logic uv_in_standby
);
  logic       mdc_q;
  logic [3:0] mdc_age;
  logic [3:0] clr_age;
  logic [4:0] oe_rises;
  wire        clr_any = enter_sleep_request | enter_standby_uv | uv_in_standby;
  wire        mdc_rise = mdc & ~mdc_q;
  // Ages saturate so a long idle never wraps back into the window
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mdc_q    <= 1'b0;
      mdc_age  <= 4'hF;
      clr_age  <= 4'hF;
      oe_rises <= 5'h00;
    end else begin
      mdc_q    <= mdc;
      mdc_age  <= mdc_rise ? 4'h0 : mdc_age + {3'h0, mdc_age != 4'hF};
      clr_age  <= clr_any ? 4'h0 : clr_age + {3'h0, clr_age != 4'hF};
      oe_rises <= mdio_oe ? oe_rises + {4'h0, mdc_rise} : 5'h00;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_irq_in_reset; disable iff (1'b0) rst |-> event_irq_n; endproperty
  a_irq_in_reset: assert property (p_irq_in_reset) else $error("irq low in reset");
  property p_irq_release; $fell(rst) |=> !event_irq_n; endproperty
  a_irq_release: assert property (p_irq_release) else $error("power-on irq missing");
  property p_oe_reset; disable iff (1'b0) rst |-> !mdio_oe && !mdio_out; endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("mdio driven in reset");
  property p_ta_zero; $rose(mdio_oe) |-> !mdio_out; endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
  property p_oe_len; $fell(mdio_oe) |-> oe_rises == 5'h11; endproperty
  a_oe_len: assert property (p_oe_len) else $error("read drive length wrong");
  property p_oe_on_rise; $changed(mdio_oe) |-> mdc_age <= 4'h7; endproperty
  a_oe_on_rise: assert property (p_oe_on_rise) else $error("oe moved off mdc rise");
  property p_bit_stands; mdio_oe && !mdc && !$past(mdc) |-> $stable(mdio_out); endproperty
  a_bit_stands: assert property (p_bit_stands) else $error("data bit unstable");
  property p_irq_rise; $rose(event_irq_n) |-> mdc_age <= 4'h9 || clr_age <= 4'h3; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("flag dropped by itself");
  c_read: cover property ($rose(mdio_oe));
  c_irq_set: cover property ($fell(event_irq_n));
  c_irq_clr: cover property ($rose(event_irq_n));
endmodule : pesb_checker
`default_nettype wire

// ---- tb/pesb_host.sv ----
// Management host model driving clause 22 frames
`timescale 1ns/100ps
`default_nettype none
module pesb_host (
  // Clock
  input  wire logic core_clk,
  // Management pins
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  localparam int HALF = 6;
  logic drv = 1'b1;
  logic drv_en = 1'b0;
  // Pulled-up line: released, it reads high rather than the last bit
  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);
  initial mdc = 1'b0;
  // 150 ns half period keeps above the slave's synchroniser needs
  task automatic bit_cyc(input logic b, input logic oe, output logic s);
    mdc = 1'b0;
    drv = b;
    drv_en = oe;
    repeat (HALF) @(negedge core_clk);
    s = mdio_in;
    mdc = 1'b1;
    repeat (HALF) @(negedge core_clk);
  endtask : bit_cyc
  task automatic xfer(input logic [13:0] hdr, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic        rdop;
    logic        s;
    f = {32'hFFFF_FFFF, hdr, 2'h2, wd};
    rdop = (hdr[11:10] == 2'h2);
    rd = 16'h0000;
    @(negedge core_clk);
    for (int i = 63; i >= 0; i--) begin
      bit_cyc(f[i], !(rdop && i < 18), s);
      rd = {rd[14:0], s};
    end
    bit_cyc(1'b1, 1'b0, s);
  endtask : xfer
endmodule : pesb_host
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the event status block
`timescale 1ns/100ps
`default_nettype none
bind pesb_top pesb_checker pesb_checker_i (.core_clk(core_clk), .rst(rst), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .event_irq_n(event_irq_n), .enter_sleep_request(enter_sleep_request),
  .enter_standby_uv(enter_standby_uv), .uv_in_standby(uv_in_standby));
module testbench;
  import pesb_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b0;
  logic        mdc;
  logic        mdio_in;
  logic        mdio_out;
  logic        mdio_oe;
  logic        event_irq_n;
  logic [15:0] ev = 16'h0000;
  logic        rwake = 1'b0;
  logic        in_pkt = 1'b0;
  logic        link_up = 1'b0;
  logic        snr = 1'b0;
  logic [2:0]  clr = 3'h0;
  logic [15:0] seed = 16'h004C;
  logic [15:0] en;
  logic [15:0] m;
  logic [15:0] d;
  logic [15:0] cnt = 16'h0000;
  int          mismatches = 0;
  int          checked = 0;
  always #12.5 core_clk = ~core_clk;
  pesb_top pesb_top_i (.core_clk(core_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .rx_bad_symbol(ev[8]), .rx_in_packet(in_pkt), .link_up(link_up),
    .training_fail_flag(ev[7]), .init_error(ev[11]), .snr_below_warn(snr), .local_wake(ev[14]),
    .remote_wake(rwake), .wake_request_seen(ev[13]), .low_power_sleep_code(ev[12]),
    .sleep_timer_expired(ev[0]), .enter_sleep_request(clr[0]), .enter_standby_uv(clr[1]),
    .uv_in_standby(clr[2]), .transmit_enable_input_stuck(ev[4]), .supply_low(ev[3]),
    .supply_restored(ev[2]), .overtemp(ev[1]), .event_irq_n(event_irq_n));
  pesb_host pesb_host_i (.core_clk(core_clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic irq_exp(input logic [15:0] st, input logic [15:0] e);
    return !(|(st & e));
  endfunction : irq_exp
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    pesb_host_i.xfer({SMI_START, SMI_OP_READ, PHY_ADDR_DEFAULT, a}, 16'h0000, v);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    logic [15:0] x;
    pesb_host_i.xfer({SMI_START, SMI_OP_WRITE, PHY_ADDR_DEFAULT, a}, v, x);
  endtask : wr
  // Bit 14 alternates between its two wake sources
  task automatic pulse(input logic [15:0] v, input logic alt);
    @(negedge core_clk);
    ev = alt ? (v & 16'hBFFF) : v;
    rwake = alt & v[14];
    @(negedge core_clk);
    ev = 16'h0000;
    rwake = 1'b0;
    idle(4);
  endtask : pulse
  initial begin
    // About 90k cycles expected, most of them spent saturating the counter
    #2450000;
    mismatches++;
    conclude();
  end
  initial begin
    // A real rising edge resets the design before the first clock edge
    #1 rst = 1'b1;
    idle(16);
    rst = 1'b0;
    idle(2);
    check({15'h0, event_irq_n}, {15'h0, irq_exp(STATUS_RESET, ENABLE_RESET)});
    rd(REG_EVENT_STATUS, d);
    check(d, 16'h8000);
    rd(REG_EVENT_ENABLE, d);
    check(d, 16'h8000);
    rd(REG_SYMBOL_ERROR_COUNTER, d);
    check(d, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      en = seed;
      wr(REG_EVENT_ENABLE, en);
      seed = lfsr(seed);
      m = (k == 0) ? 16'h799F : seed & 16'h799F;
      pulse(m, k[0]);
      cnt = cnt + {15'h0, m[8]};
      check({15'h0, event_irq_n}, {15'h0, irq_exp(m, en)});
      rd(REG_EVENT_STATUS, d);
      check(d, m);
      check({15'h0, event_irq_n}, 16'h0001);
    end
    link_up = 1'b1;
    idle(4);
    snr = 1'b1;
    idle(2);
    snr = 1'b0;
    link_up = 1'b0;
    idle(4);
    rd(REG_EVENT_STATUS, d);
    check(d, 16'h0640);
    snr = 1'b1;
    idle(4);
    snr = 1'b0;
    rd(REG_EVENT_STATUS, d);
    check(d, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      link_up = 1'b1;
      snr = 1'b1;
      idle(3);
      link_up = 1'b0;
      snr = 1'b0;
      pulse(16'h0102, 1'b0);
      cnt++;
      clr[k] = 1'b1;
      idle(1);
      clr = 3'h0;
      idle(3);
      rd(REG_EVENT_STATUS, d);
      check(d, 16'h0002);
    end
    for (int k = 0; k < 3; k++)
      pesb_host_i.xfer({k == 0 ? 2'h0 : SMI_START, k == 1 ? 2'h0 : 2'h3, PHY_ADDR_DEFAULT, REG_EVENT_ENABLE},
        16'h0000, d);
    rd(REG_EVENT_STATUS, d);
    check(d, 16'h0020);
    pesb_host_i.xfer({SMI_START, SMI_OP_WRITE, PHY_ADDR_DEFAULT ^ 5'h01, REG_EVENT_ENABLE}, 16'h1234, d);
    rd(REG_EVENT_ENABLE, d);
    check(d, en);
    rd(REG_SYMBOL_ERROR_COUNTER, d);
    check(d, cnt);
    in_pkt = 1'b1;
    for (int k = 0; k < 5; k++)
      pulse(16'h0100, 1'b0);
    in_pkt = 1'b0;
    rd(REG_SYMBOL_ERROR_COUNTER, d);
    check(d, 16'h0001);
    ev[8] = 1'b1;
    idle(65540);
    rd(REG_EVENT_STATUS, d);
    check(d, 16'h0100);
    rd(REG_EVENT_STATUS, d);
    check(d, 16'h0100);
    ev[8] = 1'b0;
    rd(REG_SYMBOL_ERROR_COUNTER, d);
    check(d, 16'hFFFF);
    rd(REG_SYMBOL_ERROR_COUNTER, d);
    check(d, 16'h0000);
    conclude();
  end
endmodule : testbench
`default_nettype wire
